//--- rtl/pin_mux_pkg.sv
// constants, types and carriers for the alternate-function pin multiplexer
// How it works
// - larger parts: clock input on B3
// - 8-pin: clock input on A1, code 10
// - external clock used only when oscillator selects it
// - larger parts port A: enable bit alone selects
// - A0/A6 timer in or complement by mode
// - larger parts port A fixed eight-function map
// - port B: first set picks, second ignored
// - port B bit five reference: 28-pin only
// - port C map: analog, LED, comparator out
// - port C second set stored, never used
// - port C bit two reference: 20-pin only
// - ports B, C, 8-pin need enable bit
// - 8-pin A0: 00 timer in, 11 complement
// - 8-pin A2: UART enable, reset, timer out
// - 8-pin A3: clear-to-send, comparator, timer, analog
// - 8-pin A5: transmit, complement, reserved, analog
// - 8-pin A1/A4: timer out/receive, analog codes
// - enabled function, not direction, owns the pin
// - crystal enable dedicates A0 and A1
package pin_mux_pkg;

  // ---------------------------------------------------------------
  // register map (word index equals byte offset here)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_A_ENABLE  = 4'h0;
  localparam logic [3:0] REG_A_FIRST   = 4'h1;
  localparam logic [3:0] REG_A_SECOND  = 4'h2;
  localparam logic [3:0] REG_B_ENABLE  = 4'h3;
  localparam logic [3:0] REG_B_FIRST   = 4'h4;
  localparam logic [3:0] REG_B_SECOND  = 4'h5;
  localparam logic [3:0] REG_C_ENABLE  = 4'h6;
  localparam logic [3:0] REG_C_FIRST   = 4'h7;
  localparam logic [3:0] REG_C_SECOND  = 4'h8;
  localparam logic [3:0] REG_STATUS    = 4'h9;
  localparam int         NUM_CFG_REGS  = 9;
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // status fields
  localparam int STAT_EXT_CLK   = 0;
  localparam int STAT_CRYSTAL   = 1;
  localparam int STAT_VARIANT_L = 2;

  // ports and pins
  localparam int NUM_PORTS = 3;
  localparam int PORT_A    = 0;
  localparam int PORT_B    = 1;
  localparam int PORT_C    = 2;
  localparam int SMALL_PINS = 6;

  typedef enum logic [1:0] {
    PKG_8PIN  = 2'h0,
    PKG_20PIN = 2'h1,
    PKG_28PIN = 2'h2
  } variant_e;

  typedef enum {
    FN_NONE, FN_XTAL, FN_TMR0_IN, FN_TMR0_OUT, FN_T0N, FN_TMR1_IN, FN_TMR1_OUT, FN_T1N,
    FN_DE, FN_CTS, FN_RX, FN_TX, FN_RST, FN_CLK, FN_CMP_OUT,
    FN_ANA, FN_ANA_VREF, FN_ANA_LED, FN_ANA_LED_VREF, FN_LED, FN_VREF
  } fn_e;

  typedef logic [NUM_PORTS-1:0][7:0] port_bus_t;

  // driven by peripherals toward the pins
  typedef struct packed {
    logic timer0_pin_output;
    logic timer0_out_n;
    logic timer1_pin_output;
    logic timer1_out_n;
    logic uart_driver_enable;
    logic uart_transmit;
    logic comparator_result_out;
  } periph_out_s;

  // delivered from the pins to peripherals
  typedef struct packed {
    logic timer0_pin_input;
    logic timer1_pin_input;
    logic uart_clear_to_send;
    logic uart_receive;
    logic ext_reset_n;
    logic external_clock_input;
    logic ext_clock_routed;
  } periph_in_s;

endpackage

//--- rtl/pin_sync.sv
// two-flop synchroniser for asynchronous pad inputs
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 24
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // pin_sync
`default_nettype wire

//--- rtl/pin_mux.sv
// alternate-function multiplexer between peripherals and port A, B, C pins
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module pin_mux
  import pin_mux_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [7:0]  reg_rdata,
  // system configuration
  input  wire variant_e    variant,
  input  wire logic        crystal_enable,
  input  wire logic        osc_external_select,
  input  wire logic        timer0_output_mode,
  input  wire logic        timer1_output_mode,
  // peripherals
  input  wire periph_out_s periph_out,
  output var  periph_in_s  periph_in,
  output var  logic        ext_clock_active,
  // pads
  input  wire port_bus_t   pad_in,
  output var  port_bus_t   pad_out,
  output var  port_bus_t   pad_oe_n,
  output var  port_bus_t   pad_af_own,
  output var  port_bus_t   pad_analog,
  output var  port_bus_t   pad_led,
  output var  logic        vref_enable
);

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [7:0] cfg_r   [NUM_CFG_REGS];
  logic [7:0] cfg_nxt [NUM_CFG_REGS];
  logic [7:0] rdata_nxt;
  logic [7:0] status;

  always_comb begin
    for (int i = 0; i < NUM_CFG_REGS; i++) begin
      cfg_nxt[i] = cfg_r[i];
    end
    // second sets stored as plain storage
    if (reg_wr && (reg_addr < REG_STATUS)) begin
      cfg_nxt[reg_addr] = reg_wdata;
    end
  end

  always_comb begin
    rdata_nxt = UNMAPPED_READ;
    if (reg_rd) begin
      if (reg_addr == REG_STATUS) begin
        rdata_nxt = status;
      // larger parts have no port A sets
      end else if ((variant != PKG_8PIN) &&
                   ((reg_addr == REG_A_FIRST) || (reg_addr == REG_A_SECOND))) begin
        rdata_nxt = UNMAPPED_READ;
      end else if (reg_addr < REG_STATUS) begin
        rdata_nxt = cfg_r[reg_addr];
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_CFG_REGS; i++) begin
        cfg_r[i] <= CFG_RESET;
      end
      reg_rdata <= UNMAPPED_READ;
    end else begin
      for (int i = 0; i < NUM_CFG_REGS; i++) begin
        cfg_r[i] <= cfg_nxt[i];
      end
      reg_rdata <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // pad input synchroniser
  // ---------------------------------------------------------------
  port_bus_t pad_sync;

  pin_sync #(
    .WIDTH (NUM_PORTS * 8)
  ) u_pin_sync (
    .clock    (clock),
    .rstn     (rstn),
    .async_in (pad_in),
    .sync_out (pad_sync)
  );

  // ---------------------------------------------------------------
  // per-pin function decode
  // ---------------------------------------------------------------
  function automatic fn_e pick(input int p, input int b, input variant_e v,
                               input logic s1, input logic s2,
                               input logic t0m, input logic t1m);
    fn_e f;
    f = FN_NONE;
    if (v == PKG_8PIN) begin
      if ((p == PORT_A) && (b < SMALL_PINS)) begin
        unique case (b)
          0: f = ({s1, s2} == 2'h0) ? FN_TMR0_IN : (({s1, s2} == 2'h3) ? FN_T0N : FN_NONE);
          1: f = ({s1, s2} == 2'h0) ? FN_TMR0_OUT : ({s1, s2} == 2'h2) ? FN_CLK :
                 ({s1, s2} == 2'h3) ? FN_ANA_VREF : FN_NONE;
          2: f = ({s1, s2} == 2'h0) ? FN_DE : ({s1, s2} == 2'h1) ? FN_RST :
                 ({s1, s2} == 2'h2) ? FN_TMR1_OUT : FN_NONE;
          3: f = ({s1, s2} == 2'h0) ? FN_CTS : ({s1, s2} == 2'h1) ? FN_CMP_OUT :
                 ({s1, s2} == 2'h2) ? FN_TMR1_IN : FN_ANA;
          4: f = ({s1, s2} == 2'h0) ? FN_RX : (({s1, s2} == 2'h3) ? FN_ANA : FN_NONE);
          default: f = ({s1, s2} == 2'h0) ? FN_TX : ({s1, s2} == 2'h1) ? FN_T1N :
                       ({s1, s2} == 2'h3) ? FN_ANA : FN_NONE;
        endcase
      end
    end else if (p == PORT_A) begin
      // fixed map, timer mode picks direction
      unique case (b)
        0: f = t0m ? FN_T0N : FN_TMR0_IN;
        1: f = FN_TMR0_OUT;
        2: f = FN_DE;
        3: f = FN_CTS;
        4: f = FN_RX;
        5: f = FN_TX;
        6: f = t1m ? FN_T1N : FN_TMR1_IN;
        default: f = FN_TMR1_OUT;
      endcase
    end else if (p == PORT_B) begin
      if (s1) begin
        if (b <= 4) begin
          f = FN_ANA;
        end else if ((b == 5) && (v == PKG_28PIN)) begin
          f = FN_VREF;
        end
      // clock input on port B bit three
      end else if (b == 3) begin
        f = FN_CLK;
      end
    end else begin
      // port C map, second set ignored
      if (s1) begin
        if (b <= 1) begin
          f = FN_ANA_LED;
        end else if (b == 2) begin
          f = (v == PKG_20PIN) ? FN_ANA_LED_VREF : FN_ANA_LED;
        end else begin
          f = FN_LED;
        end
      end else if (b == 3) begin
        f = FN_CMP_OUT;
      end
    end
    return f;
  endfunction

  fn_e       fn_sel [NUM_PORTS][8];
  port_bus_t out_nxt;
  port_bus_t oe_n_nxt;
  port_bus_t own_nxt;
  port_bus_t ana_nxt;
  port_bus_t led_nxt;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    for (genvar b = 0; b < 8; b++) begin : g_bit
      logic en;
      logic xtal;
      assign en   = cfg_r[p*3][b];
      assign xtal = crystal_enable && (p == PORT_A) && (b <= 1);

      always_comb begin
        fn_sel[p][b] = xtal ? FN_XTAL :
                       en   ? pick(p, b, variant, cfg_r[p*3+1][b], cfg_r[p*3+2][b],
                                   timer0_output_mode, timer1_output_mode) : FN_NONE;
        own_nxt[p][b]  = en || xtal;
        // reserved or input functions leave driver off
        oe_n_nxt[p][b] = 1'b1;
        out_nxt[p][b]  = 1'b0;
        ana_nxt[p][b]  = 1'b0;
        led_nxt[p][b]  = 1'b0;
        unique case (fn_sel[p][b])
          FN_TMR0_OUT: begin
            oe_n_nxt[p][b] = 1'b0;
            out_nxt[p][b]  = periph_out.timer0_pin_output;
          end
          FN_T0N: begin
            oe_n_nxt[p][b] = 1'b0;
            out_nxt[p][b]  = periph_out.timer0_out_n;
          end
          FN_TMR1_OUT: begin
            oe_n_nxt[p][b] = 1'b0;
            out_nxt[p][b]  = periph_out.timer1_pin_output;
          end
          FN_T1N: begin
            oe_n_nxt[p][b] = 1'b0;
            out_nxt[p][b]  = periph_out.timer1_out_n;
          end
          FN_DE: begin
            oe_n_nxt[p][b] = 1'b0;
            out_nxt[p][b]  = periph_out.uart_driver_enable;
          end
          FN_TX: begin
            oe_n_nxt[p][b] = 1'b0;
            out_nxt[p][b]  = periph_out.uart_transmit;
          end
          FN_CMP_OUT: begin
            oe_n_nxt[p][b] = 1'b0;
            out_nxt[p][b]  = periph_out.comparator_result_out;
          end
          FN_ANA, FN_ANA_VREF, FN_VREF: begin
            ana_nxt[p][b] = 1'b1;
          end
          FN_ANA_LED, FN_ANA_LED_VREF: begin
            ana_nxt[p][b] = 1'b1;
            led_nxt[p][b] = 1'b1;
          end
          FN_LED: begin
            led_nxt[p][b] = 1'b1;
          end
          default: begin
            oe_n_nxt[p][b] = 1'b1;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // pin to peripheral routing
  // ---------------------------------------------------------------
  periph_in_s in_nxt;
  logic       vref_nxt;
  logic       ext_active_nxt;

  always_comb begin
    in_nxt                      = '0;
    in_nxt.uart_receive         = 1'b1;
    in_nxt.uart_clear_to_send   = 1'b1;
    in_nxt.ext_reset_n          = 1'b1;
    vref_nxt                    = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      for (int b = 0; b < 8; b++) begin
        unique case (fn_sel[p][b])
          FN_TMR0_IN: in_nxt.timer0_pin_input = pad_sync[p][b];
          FN_TMR1_IN: in_nxt.timer1_pin_input = pad_sync[p][b];
          FN_CTS:  in_nxt.uart_clear_to_send = pad_sync[p][b];
          FN_RX:   in_nxt.uart_receive       = pad_sync[p][b];
          FN_RST:  in_nxt.ext_reset_n        = pad_sync[p][b];
          FN_CLK: begin
            in_nxt.external_clock_input = pad_sync[p][b];
            in_nxt.ext_clock_routed     = 1'b1;
          end
          FN_ANA_VREF, FN_ANA_LED_VREF, FN_VREF: vref_nxt = 1'b1;
          default: vref_nxt = vref_nxt;
        endcase
      end
    end
    ext_active_nxt = in_nxt.ext_clock_routed && osc_external_select;
  end

  always_comb begin
    status                                   = 8'h00;
    status[STAT_EXT_CLK]                     = ext_clock_active;
    status[STAT_CRYSTAL]                     = crystal_enable;
    status[STAT_VARIANT_L +: 2]              = variant;
  end

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pad_out          <= '0;
      pad_oe_n         <= '1;
      pad_af_own       <= '0;
      pad_analog       <= '0;
      pad_led          <= '0;
      vref_enable      <= 1'b0;
      ext_clock_active <= 1'b0;
      periph_in        <= '0;
    end else begin
      pad_out          <= out_nxt;
      pad_oe_n         <= oe_n_nxt;
      pad_af_own       <= own_nxt;
      pad_analog       <= ana_nxt;
      pad_led          <= led_nxt;
      vref_enable      <= vref_nxt;
      ext_clock_active <= ext_active_nxt;
      periph_in        <= in_nxt;
    end
  end

endmodule // pin_mux
`default_nettype wire

//--- verif/pad_world_model.sv
// far-side model: peripheral drive levels and resolved pad wires
`timescale 1ns/1ns
`default_nettype none
module pad_world_model
  import pin_mux_pkg::*;
(
  // design side
  input  wire port_bus_t   pad_out,
  input  wire port_bus_t   pad_oe_n,
  // levels from the bench
  input  wire port_bus_t   ext_level,
  input  wire periph_out_s periph_set,
  // toward the design
  output var  port_bus_t   pad_in,
  output var  periph_out_s periph_out
);
  always_comb begin
    pad_in = (pad_out & ~pad_oe_n) | (ext_level & pad_oe_n);
    periph_out = periph_set;
  end
endmodule // pad_world_model
`default_nettype wire

//--- verif/pin_mux_checker.sv
// concurrent checks on the pin multiplexer ports
`timescale 1ns/1ns
`default_nettype none
module pin_mux_checker
  import pin_mux_pkg::*;
(
  // clock, reset, register port
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  // configuration
  input wire variant_e    variant,
  input wire logic        crystal_enable,
  input wire logic        osc_external_select,
  input wire logic        timer0_output_mode,
  // outputs
  input wire periph_out_s periph_out,
  input wire logic        ext_clock_active,
  input wire port_bus_t   pad_out,
  input wire port_bus_t   pad_oe_n,
  input wire port_bus_t   pad_af_own,
  input wire port_bus_t   pad_analog,
  input wire logic        vref_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // ------------------------------
  // shadow of configuration
  // ------------------------------
  logic [8:0][7:0] cfg_r;
  logic [8:0][7:0] cfg_nxt;
  logic            big;
  assign big = variant != PKG_8PIN;
  always_comb begin
    cfg_nxt = cfg_r;
    if (reg_wr && reg_addr < 4'h9) begin
      cfg_nxt[reg_addr] = reg_wdata;
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end
  sequence s_clk_big;
    big && cfg_r[3][3] && !cfg_r[4][3] && osc_external_select;
  endsequence
  sequence s_clk_small;
    !big && !crystal_enable && cfg_r[0][1] && cfg_r[1][1] && !cfg_r[2][1] && osc_external_select;
  endsequence
  AST_CLK_BIG: assert property (s_clk_big |=> ext_clock_active)
    else $error("clock input not active");
  AST_CLK_SMALL: assert property (s_clk_small |=> ext_clock_active)
    else $error("small clock input not active");
  AST_OSC_GATE: assert property (!osc_external_select |=> !ext_clock_active)
    else $error("clock active without select");
  AST_A_TX: assert property (big && cfg_r[0][5] |=>
    !pad_oe_n[0][5] && pad_out[0][5] == $past(periph_out.uart_transmit))
    else $error("transmit not on pin");
  AST_T0_MODE: assert property (big && cfg_r[0][0] && !crystal_enable |=>
    pad_oe_n[0][0] == !$past(timer0_output_mode))
    else $error("timer pin direction wrong");
  AST_OWN: assert property (1'b1 |-> pad_af_own[2:1] == $past({cfg_r[6], cfg_r[3]}))
    else $error("ownership differs from enable");
  AST_B_VREF: assert property (variant == PKG_28PIN && cfg_r[3][5] && cfg_r[4][5] |=> vref_enable)
    else $error("reference missing");
  AST_C_COMPARATOR_RESULT_OUT: assert property (big && cfg_r[6][3] && !cfg_r[7][3] |=>
    !pad_oe_n[2][3] && pad_out[2][3] == $past(periph_out.comparator_result_out))
    else $error("comparator out not on pin");
  AST_RSVD: assert property (!big && !crystal_enable && cfg_r[0][0] && (cfg_r[1][0] != cfg_r[2][0]) |=>
    pad_oe_n[0][0] && !pad_analog[0][0])
    else $error("reserved code drives pin");
  AST_SMALL_RST: assert property (!big && cfg_r[0][2] && !cfg_r[1][2] && cfg_r[2][2] |=>
    pad_oe_n[0][2] && pad_af_own[0][2])
    else $error("reset pin not input");
  AST_XTAL: assert property (crystal_enable |=>
    pad_af_own[0][1:0] == 2'h3 && pad_oe_n[0][1:0] == 2'h3)
    else $error("crystal pins not released");
endmodule // pin_mux_checker
bind pin_mux pin_mux_checker u_chk (
  .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .variant(variant), .crystal_enable(crystal_enable), .osc_external_select(osc_external_select),
  .timer0_output_mode(timer0_output_mode), .periph_out(periph_out), .ext_clock_active(ext_clock_active),
  .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_af_own(pad_af_own), .pad_analog(pad_analog),
  .vref_enable(vref_enable)
);
`default_nettype wire

//--- verif/pin_mux_tb.sv
// self-checking bench for the pin multiplexer
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module pin_mux_tb
  import pin_mux_pkg::*;
;
  logic        clock, rstn, reg_wr, reg_rd, crystal_enable, osc_ext, t0m, t1m;
  logic        ext_clock_active, vref_enable;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  variant_e    variant;
  periph_out_s periph_set, periph_out;
  periph_in_s  periph_in;
  port_bus_t   ext_level, pad_in, pad_out, pad_oe_n, pad_af_own, pad_analog, pad_led;
  int          bad_count, comparisons;
  logic [3:0]  drv [6] = '{4'h8, 4'h1, 4'h5, 4'h2, 4'h0, 4'h3};

  pad_world_model u_world (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_level(ext_level),
    .periph_set(periph_set), .pad_in(pad_in), .periph_out(periph_out));
  pin_mux dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .variant(variant),
    .crystal_enable(crystal_enable), .osc_external_select(osc_ext), .timer0_output_mode(t0m),
    .timer1_output_mode(t1m), .periph_out(periph_out), .periph_in(periph_in),
    .ext_clock_active(ext_clock_active), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_af_own(pad_af_own), .pad_analog(pad_analog), .pad_led(pad_led), .vref_enable(vref_enable));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask

  task automatic settle;
    repeat (4) @(posedge clock);
    #1;
  endtask

  task automatic finish_test;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    finish_test;
  end

  initial begin
    {rstn, reg_wr, reg_rd, crystal_enable, osc_ext, t0m, t1m} = '0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    variant = PKG_8PIN;
    periph_set = '0;
    ext_level = '0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(i[3:0], CFG_RESET);
      wr(i[3:0], 8'h5A ^ i[7:0]);
      rd(i[3:0], 8'h5A ^ i[7:0]);
      wr(i[3:0], 8'h00);
    end
    wr(REG_STATUS, 8'hFF);
    rd(REG_STATUS, 8'h00);
    rd(4'hF, UNMAPPED_READ);
    @(posedge clock);
    osc_ext <= 1'b1;
    for (int p = 0; p < 6; p++) begin
      for (int c = 0; c < 4; c++) begin
        wr(REG_A_ENABLE, 8'h00);
        wr(REG_A_FIRST, {7'h00, c[1]} << p);
        wr(REG_A_SECOND, {7'h00, c[0]} << p);
        wr(REG_A_ENABLE, 8'h01 << p);
        settle;
        `CHK(pad_oe_n[0][p], !drv[p][c])
        `CHK(pad_analog[0][p], (c == 3 && p != 0 && p != 2))
        `CHK(ext_clock_active, (p == 1 && c == 2))
        `CHK(periph_in.ext_reset_n, !(p == 2 && c == 1))
        `CHK(pad_af_own[0], 8'h01 << p)
      end
    end
    @(posedge clock);
    variant <= PKG_20PIN;
    periph_set <= 7'h55;
    ext_level[0] <= 8'h41;
    wr(REG_A_FIRST, 8'hFF);
    wr(REG_A_ENABLE, 8'hFF);
    settle;
    `CHK(pad_oe_n[0], 8'h59)
    `CHK(pad_out[0] & 8'hA6, 8'h86)
    `CHK(periph_in.uart_receive, 1'b0)
    `CHK(periph_in.uart_clear_to_send, 1'b0)
    `CHK(periph_in.timer1_pin_input, 1'b1)
    `CHK(periph_in.timer0_pin_input, 1'b1)
    rd(REG_A_FIRST, 8'h00);
    @(posedge clock);
    t0m <= 1'b1;
    t1m <= 1'b1;
    periph_set <= 7'h2A;
    settle;
    `CHK(pad_oe_n[0], 8'h18)
    `CHK(pad_out[0] & 8'hE7, 8'h61)
    @(posedge clock);
    crystal_enable <= 1'b1;
    settle;
    `CHK(pad_oe_n[0][1:0], 2'h3)
    rd(REG_STATUS, 8'h06);
    @(posedge clock);
    crystal_enable <= 1'b0;
    variant <= PKG_28PIN;
    ext_level[1] <= 8'h08;
    wr(REG_A_ENABLE, 8'h00);
    wr(REG_B_FIRST, 8'h37);
    settle;
    `CHK(pad_analog[1], 8'h00)
    wr(REG_B_ENABLE, 8'h3F);
    wr(REG_B_SECOND, 8'hFF);
    settle;
    `CHK(pad_analog[1], 8'h37)
    `CHK(vref_enable, 1'b1)
    `CHK(ext_clock_active, 1'b1)
    `CHK(periph_in.external_clock_input, 1'b1)
    `CHK(periph_in.ext_clock_routed, 1'b1)
    rd(REG_STATUS, 8'h09);
    @(posedge clock);
    osc_ext <= 1'b0;
    variant <= PKG_20PIN;
    settle;
    `CHK(ext_clock_active, 1'b0)
    `CHK(vref_enable, 1'b0)
    `CHK(pad_analog[1][5], 1'b0)
    wr(REG_B_ENABLE, 8'h00);
    variant <= PKG_28PIN;
    periph_set <= 7'h01;
    wr(REG_C_SECOND, 8'hFF);
    wr(REG_C_FIRST, 8'hF6);
    wr(REG_C_ENABLE, 8'hFF);
    settle;
    `CHK(pad_led[2], 8'hF6)
    `CHK(pad_analog[2], 8'h06)
    `CHK(pad_oe_n[2][3], 1'b0)
    `CHK(pad_out[2][3], 1'b1)
    `CHK(pad_oe_n[2][0], 1'b1)
    `CHK(vref_enable, 1'b0)
    rd(REG_C_SECOND, 8'hFF);
    wr(REG_C_SECOND, 8'h00);
    variant <= PKG_20PIN;
    settle;
    `CHK(pad_led[2][3:0], 4'h6)
    `CHK(vref_enable, 1'b1)
    finish_test;
  end
endmodule // pin_mux_tb
`default_nettype wire
